// ==== src/prsm_regs.svh ====
// register offsets, field positions, reset values and counts
// assumes a 32-bit axi4-lite slave on a 100 MHz clock
`ifndef PRSM_REGS_SVH
`define PRSM_REGS_SVH
`define PRSM_CTRL_OFS    5'h00
`define PRSM_STAT_OFS    5'h04
`define PRSM_INS_OFS     5'h08
`define PRSM_DEL_OFS     5'h0C
`define PRSM_CTRL_RST    3'h4
`define PRSM_CTRL_INFER  0
`define PRSM_CTRL_LOWLAT 1
`define PRSM_CTRL_RMEN   2
`define PRSM_STAT_SYNC   0
`define PRSM_STAT_IDLE   1
`define PRSM_STAT_ERR    4
`define PRSM_STAT_LVL    16
`define PRSM_STAT_OVF    24
`define PRSM_ACQ_COMMAS  3'h4
`define PRSM_LOSE_ERRS   5'h11
`define PRSM_GOOD_LAST   4'hF
`define PRSM_OS_SKP_MAX  3'h5
`define PRSM_K285_NEG    10'h0FA
`define PRSM_K285_POS    10'h305
`define PRSM_K280_NEG    10'h0F4
`define PRSM_K280_POS    10'h30B
`define PRSM_HI_NORM     4'h6
`define PRSM_LO_NORM     4'h2
`define PRSM_HI_LL       4'h3
`define PRSM_LO_LL       4'h1
`define PRSM_ST_OK       3'h0
`define PRSM_ST_ADD      3'h1
`define PRSM_ST_DEL      3'h2
`define PRSM_RESP_OKAY   2'h0
`define PRSM_RESP_SLVERR 2'h2
`endif

// ==== src/prsm_pkg.sv ====
// types shared by the lane receive logic
// assumes prsm_regs.svh for the numeric constants
`default_nettype none
package prsm_pkg;
    typedef enum logic [2:0] {
        PRSM_LOSS = 3'b001,
        PRSM_ACQ  = 3'b010,
        PRSM_SYNC = 3'b100
    } prsm_sync_e;
    typedef struct packed {
        logic [9:0] code;
        logic       com;
        logic       skp;
    } prsm_sym_s;
    typedef logic [2:0] prsm_stat_t;
endpackage
`default_nettype wire

// ==== src/prsm_rx_lane.sv ====
// lane receive logic: signal detect, word aligner, sync, rate match
// assumes raw 10-bit words and sig detect from the serdes, axi4-lite host
`timescale 1ns/1ps
`default_nettype none
`include "prsm_regs.svh"

module prsm_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [3:0]       level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [3:0]       cnt_reg;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || DEPTH > 15) begin : g_chk
        $error("prsm_fifo depth out of range");
    end
    assign wr_ready_out = (cnt_reg != 4'(DEPTH));
    assign rd_valid_out = (cnt_reg != 4'h0);
    assign rd_data_out  = mem_reg[rp_reg];
    assign level_out    = cnt_reg;
    assign push = wr_valid_in && wr_ready_out;
    assign pop  = rd_ready_in && rd_valid_out;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wp_reg] <= wr_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= 4'h0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + 4'(push) - 4'(pop);
        end
    end
endmodule

// What this block does
// RULE1: idle output is inverted detect without inference
// RULE2: aligner runs automatic sync state machine
// RULE3: sync acquired after four K28.5 commas
// RULE4: sync lost when error count reaches 17
// RULE5: sixteen good groups remove one error
// RULE6: alignment pattern is ten bits long
// RULE7: fifo absorbs 300 ppm offset each way
// RULE8: at most one skp added/removed per set
// RULE9: skp set is COM then 1-5 SKP
// RULE10: far end sends skp sets between packets
// RULE11: rate match starts only once synchronized
// RULE12: insertions and deletions reported on status
// RULE13: low latency mode for common refclock
// RULE14: spread spectrum refclock tolerated when common
// RULE15: status uses pipe skp added/removed codes
// RULE16: rate match halts while sync lost
module prsm_rx_lane #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                sig_det_in,
    input  wire logic [9:0]          raw_word_in,
    input  wire logic                raw_vld_in,
    output prsm_pkg::prsm_sym_s      rx_sym_out,
    output logic                     rx_valid_out,
    input  wire logic                rx_ready_in,
    output logic                     elec_idle_out,
    output logic                     sync_status_out,
    output prsm_pkg::prsm_stat_t     pipe_status_out,
    input  wire logic [4:0]          s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic [4:0]          s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in
);
    localparam int SW = $bits(prsm_pkg::prsm_sym_s);

    if (FIFO_DEPTH < 8 || FIFO_DEPTH > 15) begin : g_chk
        $error("rate match fifo depth must be 8 to 15");
    end

    logic                  det_s1_reg;
    logic                  det_s2_reg;
    logic                  idle_reg;
    logic [2:0]            ctrl_reg;
    logic [9:0]            prev_reg;
    logic [3:0]            off_reg;
    logic [3:0]            off_use;
    logic                  hit;
    logic [3:0]            hit_k;
    logic [19:0]           win;
    prsm_pkg::prsm_sym_s   sym_reg;
    logic                  sym_vld_reg;
    logic                  sym_ok;
    prsm_pkg::prsm_sync_e  state_reg;
    logic [2:0]            cc_reg;
    logic [4:0]            err_reg;
    logic [3:0]            good_reg;
    logic                  synced;
    logic                  rm_on;
    logic [3:0]            hi_thr;
    logic [3:0]            lo_thr;
    logic                  wos_reg;
    logic [2:0]            skpn_reg;
    logic                  del_done_reg;
    logic                  del_now;
    logic                  f_wr;
    logic                  f_wrdy;
    prsm_pkg::prsm_sym_s   f_sym;
    logic                  f_vld;
    logic                  f_pop;
    logic [3:0]            level;
    logic                  load;
    logic                  ins_now;
    logic                  ros_reg;
    logic                  ins_done_reg;
    prsm_pkg::prsm_sym_s   out_reg;
    logic                  out_vld_reg;
    prsm_pkg::prsm_stat_t  stat_reg;
    logic                  del_pend_reg;
    logic                  ovf_reg;
    logic [15:0]           ins_cnt_reg;
    logic [15:0]           del_cnt_reg;
    logic                  aw_full_reg;
    logic [4:0]            aw_addr_reg;
    logic                  w_full_reg;
    logic [31:0]           w_data_reg;
    logic [3:0]            w_strb_reg;
    logic                  wr_go;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  rvalid_reg;
    logic [31:0]           rdata_reg;
    logic [1:0]            rresp_reg;

    // pin synchroniser and idle report
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            det_s1_reg <= 1'b0;
            det_s2_reg <= 1'b0;
            idle_reg   <= 1'b1;
        end else begin
            det_s1_reg <= sig_det_in;
            det_s2_reg <= det_s1_reg;
            if (ctrl_reg[`PRSM_CTRL_INFER]) begin
                idle_reg <= !synced;
            end else begin
                idle_reg <= !det_s2_reg; // RULE1
            end
        end
    end

    // comma search over every 10-bit offset
    assign win = {prev_reg, raw_word_in};
    always_comb begin
        hit   = 1'b0;
        hit_k = 4'h0;
        for (int k = 9; k >= 0; k--) begin
            if (win[k +: 10] == `PRSM_K285_NEG || win[k +: 10] == `PRSM_K285_POS) begin // RULE6
                hit   = 1'b1;
                hit_k = 4'(k);
            end
        end
        off_use = (state_reg == prsm_pkg::PRSM_LOSS && hit) ? hit_k : off_reg;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev_reg    <= 10'h000;
            off_reg     <= 4'h0;
            sym_reg     <= '0;
            sym_vld_reg <= 1'b0;
        end else begin
            sym_vld_reg <= raw_vld_in;
            if (raw_vld_in) begin
                prev_reg     <= raw_word_in;
                off_reg      <= off_use;
                sym_reg.code <= win[off_use +: 10];
                sym_reg.com  <= (win[off_use +: 10] == `PRSM_K285_NEG)
                             || (win[off_use +: 10] == `PRSM_K285_POS);
                sym_reg.skp  <= (win[off_use +: 10] == `PRSM_K280_NEG)
                             || (win[off_use +: 10] == `PRSM_K280_POS);
            end
        end
    end

    // balanced-weight check stands in for code validity
    assign sym_ok = ($countones(sym_reg.code) >= 4) && ($countones(sym_reg.code) <= 6);
    assign synced = (state_reg == prsm_pkg::PRSM_SYNC);

    always_ff @(posedge clk_in) begin // RULE2
        if (!rst_n_in) begin
            state_reg <= prsm_pkg::PRSM_LOSS;
            cc_reg    <= 3'h0;
            err_reg   <= 5'h00;
            good_reg  <= 4'h0;
        end else if (sym_vld_reg) begin
            case (state_reg)
                prsm_pkg::PRSM_LOSS: begin
                    if (sym_reg.com) begin
                        state_reg <= prsm_pkg::PRSM_ACQ;
                        cc_reg    <= 3'h1;
                    end
                end
                prsm_pkg::PRSM_ACQ: begin
                    if (!sym_ok) begin
                        state_reg <= prsm_pkg::PRSM_LOSS;
                    end else if (sym_reg.com) begin
                        cc_reg <= cc_reg + 3'h1;
                        if (cc_reg == `PRSM_ACQ_COMMAS - 3'h1) begin // RULE3
                            state_reg <= prsm_pkg::PRSM_SYNC;
                            err_reg   <= 5'h00;
                            good_reg  <= 4'h0;
                        end
                    end
                end
                prsm_pkg::PRSM_SYNC: begin
                    if (!sym_ok) begin
                        good_reg <= 4'h0;
                        if (err_reg == `PRSM_LOSE_ERRS - 5'h01) begin // RULE4
                            state_reg <= prsm_pkg::PRSM_LOSS;
                            err_reg   <= 5'h00;
                        end else begin
                            err_reg <= err_reg + 5'h01;
                        end
                    end else if (good_reg == `PRSM_GOOD_LAST) begin // RULE5
                        good_reg <= 4'h0;
                        if (err_reg != 5'h00) begin
                            err_reg <= err_reg - 5'h01;
                        end
                    end else begin
                        good_reg <= good_reg + 4'h1;
                    end
                end
                default: state_reg <= prsm_pkg::PRSM_LOSS;
            endcase
        end
    end

    // rate match, gated by sync; a common spread refclock tracks within the thresholds
    assign rm_on  = synced && ctrl_reg[`PRSM_CTRL_RMEN]; // RULE11 RULE16 RULE14
    assign hi_thr = ctrl_reg[`PRSM_CTRL_LOWLAT] ? `PRSM_HI_LL : `PRSM_HI_NORM; // RULE13
    assign lo_thr = ctrl_reg[`PRSM_CTRL_LOWLAT] ? `PRSM_LO_LL : `PRSM_LO_NORM; // RULE13
    // far end keeps skp sets in the packet gap, so dropping one skp never cuts data
    assign del_now = sym_vld_reg && rm_on && sym_reg.skp && wos_reg && !del_done_reg
                  && (skpn_reg != 3'h0) && (level >= hi_thr); // RULE7 RULE8 RULE10
    assign f_wr    = sym_vld_reg && !del_now;

    always_ff @(posedge clk_in) begin // RULE9
        if (!rst_n_in) begin
            wos_reg      <= 1'b0;
            skpn_reg     <= 3'h0;
            del_done_reg <= 1'b0;
        end else if (sym_vld_reg) begin
            if (sym_reg.com) begin
                wos_reg      <= 1'b1;
                skpn_reg     <= 3'h0;
                del_done_reg <= 1'b0;
            end else if (sym_reg.skp && wos_reg && skpn_reg != `PRSM_OS_SKP_MAX) begin
                skpn_reg <= skpn_reg + 3'h1;
                if (del_now) begin
                    del_done_reg <= 1'b1;
                end
            end else begin
                wos_reg <= 1'b0;
            end
        end
    end

    prsm_fifo #(
        .WIDTH (SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (sym_reg),
        .wr_valid_in  (f_wr),
        .wr_ready_out (f_wrdy),
        .rd_data_out  (f_sym),
        .rd_valid_out (f_vld),
        .rd_ready_in  (f_pop),
        .level_out    (level)
    );

    // read side: repeat one skp per set when the fifo runs low
    assign load    = !out_vld_reg || rx_ready_in;
    assign ins_now = load && f_vld && rm_on && f_sym.skp && ros_reg && !ins_done_reg
                  && (level <= lo_thr); // RULE7 RULE8
    assign f_pop   = load && !ins_now;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_reg      <= '0;
            out_vld_reg  <= 1'b0;
            ros_reg      <= 1'b0;
            ins_done_reg <= 1'b0;
        end else if (load) begin
            out_reg     <= f_sym;
            out_vld_reg <= f_vld;
            if (ins_now) begin
                ins_done_reg <= 1'b1;
            end else if (f_vld && f_sym.com) begin
                ros_reg      <= 1'b1;
                ins_done_reg <= 1'b0;
            end else if (f_vld && !f_sym.skp) begin
                ros_reg <= 1'b0;
            end
        end
    end

    // status codes; a deletion colliding with an insertion reports next cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stat_reg     <= `PRSM_ST_OK;
            del_pend_reg <= 1'b0;
        end else if (ins_now) begin
            stat_reg     <= `PRSM_ST_ADD; // RULE12 RULE15
            del_pend_reg <= del_pend_reg || del_now;
        end else if (del_now || del_pend_reg) begin
            stat_reg     <= `PRSM_ST_DEL; // RULE12 RULE15
            del_pend_reg <= 1'b0;
        end else begin
            stat_reg <= `PRSM_ST_OK; // RULE15
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ins_cnt_reg <= 16'h0000;
            del_cnt_reg <= 16'h0000;
            ovf_reg     <= 1'b0;
        end else begin
            ins_cnt_reg <= ins_cnt_reg + 16'(ins_now);
            del_cnt_reg <= del_cnt_reg + 16'(del_now);
            if (f_wr && !f_wrdy) begin
                ovf_reg <= 1'b1;
            end else if (wr_go && aw_addr_reg == `PRSM_STAT_OFS && w_strb_reg[3]
                         && w_data_reg[`PRSM_STAT_OVF]) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // axi4-lite slave
    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_full_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PRSM_RESP_OKAY;
            ctrl_reg    <= `PRSM_CTRL_RST;
        end else begin
            if (s_axi_awvalid_in && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (aw_addr_reg[4] == 1'b0) ? `PRSM_RESP_OKAY : `PRSM_RESP_SLVERR;
                if ({aw_addr_reg[4:2], 2'b00} == `PRSM_CTRL_OFS && w_strb_reg[0]) begin
                    ctrl_reg <= w_data_reg[2:0];
                end
            end else if (bvalid_reg && s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `PRSM_RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `PRSM_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            case ({s_axi_araddr_in[4:2], 2'b00})
                `PRSM_CTRL_OFS: rdata_reg <= {29'h0000_0000, ctrl_reg};
                `PRSM_STAT_OFS: begin
                    rdata_reg[`PRSM_STAT_SYNC]     <= synced;
                    rdata_reg[`PRSM_STAT_IDLE]     <= idle_reg;
                    rdata_reg[`PRSM_STAT_ERR +: 5] <= err_reg;
                    rdata_reg[`PRSM_STAT_LVL +: 4] <= level;
                    rdata_reg[`PRSM_STAT_OVF]      <= ovf_reg;
                end
                `PRSM_INS_OFS:  rdata_reg <= {16'h0000, ins_cnt_reg};
                `PRSM_DEL_OFS:  rdata_reg <= {16'h0000, del_cnt_reg};
                default:        rresp_reg <= `PRSM_RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready_out = !aw_full_reg;
    assign s_axi_wready_out  = !w_full_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;
    assign rx_sym_out        = out_reg;
    assign rx_valid_out      = out_vld_reg;
    assign elec_idle_out     = idle_reg;
    assign sync_status_out   = synced;
    assign pipe_status_out   = stat_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    idle_inverts_a: assert property ( // RULE1
        $past(rst_n_in) && !$past(ctrl_reg[`PRSM_CTRL_INFER]) |-> elec_idle_out == !$past(det_s2_reg))
        else $error("idle does not follow inverted detect");
    sync_gain_a: assert property ( // RULE3
        $rose(sync_status_out) |-> $past(cc_reg) == 3'h3 && $past(sym_reg.com) && $past(sym_vld_reg))
        else $error("sync gained without fourth comma");
    sync_loss_a: assert property ( // RULE4
        $fell(sync_status_out) |-> $past(err_reg) == 5'h10 && !$past(sym_ok))
        else $error("sync lost at wrong error count");
    err_decay_a: assert property ( // RULE5
        synced && sym_vld_reg && sym_ok && good_reg == 4'hF && err_reg != 5'h00
        |=> err_reg == $past(err_reg) - 5'h01)
        else $error("error count not reduced after good run");
    rm_gated_a: assert property ( // RULE11
        pipe_status_out != 3'h0 |-> $past(sync_status_out))
        else $error("rate match while not synchronized");
    one_del_a: assert property ( // RULE8
        del_now |=> !del_now ##1 !del_now)
        else $error("second skp removed in one set");
    add_code_a: assert property ( // RULE12
        ins_now |=> pipe_status_out == 3'h1)
        else $error("skp added not reported");
    del_code_a: assert property ( // RULE15
        del_now && !ins_now |=> pipe_status_out == 3'h2)
        else $error("skp removed not reported");
    quiet_code_a: assert property ( // RULE15
        !ins_now && !del_now && !del_pend_reg |=> pipe_status_out == 3'h0)
        else $error("status not idle without event");
    com_match_a: assert property ( // RULE6
        sym_vld_reg && sym_reg.com |-> sym_reg.code == 10'h0FA || sym_reg.code == 10'h305)
        else $error("comma flag on wrong pattern");
endmodule

`default_nettype wire

// ==== tb/prsm_far_tx.sv ====
// far-end lane transmitter model feeding raw 10-bit words
// assumes the lane samples words on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
`include "prsm_regs.svh"
module prsm_far_tx (
    input  wire logic       clk_in,
    output logic      [9:0] raw_word_out,
    output logic            raw_vld_out
);
    initial begin
        raw_word_out = 10'h000;
        raw_vld_out  = 1'b0;
    end
    task automatic send(input logic [9:0] w);
        @(posedge clk_in);
        raw_word_out <= w;
        raw_vld_out  <= 1'b1;
    endtask
    // released line shows inverse of last word
    task automatic idle();
        @(posedge clk_in);
        raw_word_out <= ~raw_word_out;
        raw_vld_out  <= 1'b0;
    endtask
    // skp set only in the gap after a packet
    task automatic skp_set(input int n);
        int i;
        send(`PRSM_K285_NEG);
        for (i = 0; i < n; i++) send(`PRSM_K280_NEG);
        idle();
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the lane receive logic
// assumes far-end model and axi4-lite master tasks here
`timescale 1ns/1ps
`default_nettype none
`include "prsm_regs.svh"
module tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, sig_det = 1'b0, rx_ready = 1'b1;
    logic [9:0] raw_word;
    logic raw_vld, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rd, rdat;
    logic [1:0] br, rr, rsp;
    logic awr, wr, bv, arr, rv, rxv, eidle, sync, found;
    prsm_pkg::prsm_sym_s sym;
    prsm_pkg::prsm_stat_t pst;
    int failures = 0, total_checks = 0, i;
    always #5 clk_in = ~clk_in;
    prsm_far_tx far (.clk_in(clk_in), .raw_word_out(raw_word), .raw_vld_out(raw_vld));
    prsm_rx_lane uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sig_det_in(sig_det), .raw_word_in(raw_word),
        .raw_vld_in(raw_vld), .rx_sym_out(sym), .rx_valid_out(rxv), .rx_ready_in(rx_ready),
        .elec_idle_out(eidle), .sync_status_out(sync), .pipe_status_out(pst), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        failures++;
        report_and_stop();
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        if (n == 50) tmo();
        rsp = br;
        bre <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_in);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        if (n == 50) tmo();
        d = rd; r = rr;
        rre <= 1'b0;
    endtask
    task automatic wait_stat(input prsm_pkg::prsm_stat_t c, output logic f);
        int n;
        f = 1'b0;
        for (n = 0; n < 30; n++) begin
            @(posedge clk_in);
            if (pst === c) f = 1'b1;
        end
    endtask
    task automatic burst(input logic [9:0] w, input int n);
        for (i = 0; i < n; i++) far.send(w);
        far.idle();
        repeat (4) @(posedge clk_in);
    endtask
    task automatic t_reset_regs();
        chk(eidle, 1'b1);
        chk(sync, 1'b0);
        axi_rd(`PRSM_CTRL_OFS, rdat, rsp);
        chk(rdat, `PRSM_CTRL_RST);
        axi_rd(5'h14, rdat, rsp);
        chk(rsp, `PRSM_RESP_SLVERR);
        axi_wr(5'h10, 32'h0000_0000);
        chk(rsp, `PRSM_RESP_SLVERR);
    endtask
    task automatic t_detect();
        @(posedge clk_in) sig_det <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(eidle, 1'b0);
    endtask
    task automatic t_acquire();
        burst(`PRSM_K285_NEG, 3);
        chk(sync, 1'b0);
        burst(`PRSM_K285_POS, 1);
        chk(sync, 1'b1);
    endtask
    task automatic t_rate_match();
        far.skp_set(2);
        wait_stat(`PRSM_ST_ADD, found);
        chk(found, 1'b1);
        chk(pst, `PRSM_ST_OK);
        @(posedge clk_in) rx_ready <= 1'b0;
        burst(10'h155, 6);
        far.skp_set(3);
        wait_stat(`PRSM_ST_DEL, found);
        chk(found, 1'b1);
        chk(rxv, 1'b1);
        chk(sym, {10'h155, 2'b00});
        burst(10'h155, 8);
        axi_rd(`PRSM_STAT_OFS, rdat, rsp);
        chk(rdat[`PRSM_STAT_OVF], 1'b1);
        axi_wr(`PRSM_STAT_OFS, 32'h0100_0000);
        chk(rsp, `PRSM_RESP_OKAY);
        axi_rd(`PRSM_STAT_OFS, rdat, rsp);
        chk(rdat[`PRSM_STAT_OVF], 1'b0);
        @(posedge clk_in) rx_ready <= 1'b1;
        repeat (20) @(posedge clk_in);
    endtask
    task automatic t_errors();
        burst(10'h000, 16);
        burst(10'h155, 16);
        burst(10'h000, 1);
        chk(sync, 1'b1);
        burst(10'h000, 1);
        chk(sync, 1'b0);
        far.skp_set(3);
        wait_stat(`PRSM_ST_ADD, found);
        chk(found, 1'b0);
        axi_rd(`PRSM_INS_OFS, rdat, rsp);
        chk(rdat, 32'h0000_0002);
        axi_rd(`PRSM_DEL_OFS, rdat, rsp);
        chk(rdat, 32'h0000_0001);
        axi_wr(`PRSM_CTRL_OFS, 32'h0000_0005);
        repeat (4) @(posedge clk_in);
        chk(eidle, 1'b1);
    endtask
    task automatic t_low_lat();
        axi_wr(`PRSM_CTRL_OFS, 32'h0000_0006);
        burst(10'h000, 1);
        burst(`PRSM_K285_NEG, 4);
        chk(sync, 1'b1);
        @(posedge clk_in) rx_ready <= 1'b0;
        burst(10'h155, 3);
        far.skp_set(2);
        wait_stat(`PRSM_ST_DEL, found);
        chk(found, 1'b1);
        @(posedge clk_in) rx_ready <= 1'b1;
        repeat (20) @(posedge clk_in);
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset_regs();
        t_detect();
        t_acquire();
        t_rate_match();
        t_errors();
        t_low_lat();
        report_and_stop();
    end
endmodule
`default_nettype wire
